// ### tfs_pkg.sv
package tfs_pkg;

    localparam int MEM_WORDS = 512;
    localparam int MEM_AW    = 9;
    localparam int DATA_W    = 32;
    localparam int REG_AW    = 8;

    // Register and data-port offsets on the host port
    localparam logic [7:0] ASYNC_STATUS_OFS = 8'h30;
    localparam logic [7:0] ISO_STATUS_OFS   = 8'h34;
    localparam logic [7:0] TEST_DATA_OFS    = 8'h80;
    localparam logic [7:0] ASYNC_FIRST_OFS  = 8'ha0;
    localparam logic [7:0] ASYNC_NEXT_OFS   = 8'ha4;
    localparam logic [7:0] ISO_FIRST_OFS    = 8'ha8;
    localparam logic [7:0] ISO_NEXT_OFS     = 8'hac;

    // Status register fields
    localparam int FULL_BIT     = 0;
    localparam int EMPTY_BIT    = 1;
    localparam int MISMATCH_BIT = 2;
    localparam int PTRCLR_BIT   = 3;
    localparam int MARKER_BIT   = 4;
    localparam int SELFTEST_BIT = 5;
    localparam int PTR_LSB      = 6;
    localparam int PTR_MSB      = 14;
    localparam int FREE_LSB     = 23;
    localparam int FREE_MSB     = 31;

    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

    localparam int ASYNC_DEPTH_DEF = 256;
    localparam int ISO_DEPTH_DEF   = 256;

    typedef struct packed {
        logic        first_quadlet_marker;
        logic [31:0] data;
    } tfs_word_s;

    typedef struct packed {
        logic      wr;
        logic [8:0] addr;
        tfs_word_s word;
    } tfs_mem_wr_s;

    typedef struct packed {
        logic      from_iso;
        tfs_word_s word;
    } tfs_tx_s;

endpackage : tfs_pkg

// ### tfs_store.sv
`timescale 1ns/10ps
module tfs_store
    import tfs_pkg::*;
#(
    parameter int WORDS = MEM_WORDS,
    parameter int AW    = MEM_AW
) (
    input  wire logic        ref_clk_i,
    input  wire logic        resetn_i,
    input  tfs_mem_wr_s      wr_i,
    input  wire logic        rd_en_i,
    input  wire logic [8:0]  rd_addr_i,
    output tfs_word_s        rd_word_o
);

    if (AW != MEM_AW || WORDS > (1 << AW) || WORDS < 2) begin : g_check
        $error("tfs_store: unsupported size");
    end

    tfs_word_s mem_r [WORDS];
    tfs_word_s rd_word_r;

    always_ff @(posedge ref_clk_i) begin
        if (wr_i.wr) begin
            mem_r[wr_i.addr] <= wr_i.word;
        end
    end

    // Read data leave through a register so the port timing is fixed at one cycle
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_word_r <= '0;
        end else if (rd_en_i) begin
            rd_word_r <= mem_r[rd_addr_i];
        end
    end

    assign rd_word_o = rd_word_r;

endmodule : tfs_store

// ### tfs_tx_status.sv
// What this block does
// [R01] Self-test write stores marker bit above 32 data bits at pointer location.
// [R02] Self-test read sets mismatch flag when stored marker differs from register marker.
// [R03] Self-test mode disables every normal queue function.
// [R04] In self-test, accesses at the test data address reach the pointed location.
// [R05] Each self-test storage access advances the pointer by one.
// [R06] Pointer sits in async status bits 6..14, range 0..511.
// [R07] With self-test off, queues run normally; pointer holds and a clear request is latched until the next test access.
// [R08] Async status bits 23..31 report free quadlets in that queue.
// [R09] Software checks free space, then writes the whole packet in one burst.
// [R10] Iso queue full flag makes further host writes to it ignored.
// [R11] Iso status bit 1 is set while the iso queue is empty.
// [R12] Iso status bits 23..31 report free quadlets in that queue.
// [R13] Flag bits are read-only; control bits are read/write.
// [R14] Iso status register reads all zero at reset.
// [R15] Mismatch flag clears on writing 1 to clear request or 0 to mode.
// [R16] Clear request zeroes pointer and mismatch on next access, then self-clears.
// [R17] Storage words are 33 bits; top bit marks a packet's first quadlet.
// [R18] Async queue full flag makes host writes to it ignored.
`timescale 1ns/10ps
module tfs_tx_status
    import tfs_pkg::*;
#(
    parameter int ASYNC_DEPTH = ASYNC_DEPTH_DEF,
    parameter int ISO_DEPTH   = ISO_DEPTH_DEF
) (
    input  wire logic        ref_clk_i,
    input  wire logic        resetn_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [31:0] reg_rdata_o,
    output logic             tx_valid_o,
    input  wire logic        tx_ready_i,
    output tfs_tx_s          tx_word_o
);

    if (ASYNC_DEPTH < 1 || ISO_DEPTH < 1 || ASYNC_DEPTH > 511 || ISO_DEPTH > 511
        || ASYNC_DEPTH + ISO_DEPTH > MEM_WORDS) begin : g_check
        $error("tfs_tx_status: queue depths do not fit the storage");
    end

    logic [1:0][8:0] depth_c;
    logic [1:0][8:0] base_c;
    assign depth_c[0] = 9'(ASYNC_DEPTH);
    assign depth_c[1] = 9'(ISO_DEPTH);
    assign base_c[0]  = 9'd0;
    assign base_c[1]  = 9'(ASYNC_DEPTH);

    // Control state
    logic       selftest_r;
    logic       marker_r;
    logic       ptrclr_r;
    logic       mismatch_r;
    logic [8:0] ptr_r;
    logic       test_rd_q_r;

    logic       stat_wr;
    logic       test_acc;
    logic       test_wr;
    logic       test_rd;
    logic [8:0] test_addr;
    logic       normal;
    logic       mismatch_set;

    assign stat_wr   = reg_wr_i && reg_addr_i == ASYNC_STATUS_OFS;
    assign test_wr   = selftest_r && reg_wr_i && reg_addr_i == TEST_DATA_OFS; // see [R04]
    assign test_rd   = selftest_r && reg_rd_i && reg_addr_i == TEST_DATA_OFS; // see [R04]
    assign test_acc  = test_wr || test_rd;
    assign normal    = !selftest_r; // see [R07]
    assign test_addr = ptrclr_r ? 9'd0 : ptr_r; // see [R16]

    tfs_word_s   mem_rd_word;
    tfs_mem_wr_s mem_wr;
    logic        mem_rd_en;
    logic [8:0]  mem_rd_addr;

    assign mismatch_set = test_rd_q_r
                          && mem_rd_word.first_quadlet_marker != marker_r; // see [R02]

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            selftest_r <= 1'b0;
            marker_r   <= 1'b0;
        end else if (stat_wr) begin
            selftest_r <= reg_wdata_i[SELFTEST_BIT]; // see [R13]
            marker_r   <= reg_wdata_i[MARKER_BIT];
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ptrclr_r <= 1'b0;
        end else if (stat_wr && reg_wdata_i[PTRCLR_BIT]) begin
            ptrclr_r <= 1'b1;
        end else if (test_acc) begin
            ptrclr_r <= 1'b0; // see [R16]
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ptr_r <= 9'd0;
        end else if (test_acc) begin
            ptr_r <= test_addr + 9'd1; // see [R05] [R06]
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            test_rd_q_r <= 1'b0;
        end else begin
            test_rd_q_r <= test_rd;
        end
    end

    // A mismatch found in the same cycle as a clear still reports: set wins
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mismatch_r <= 1'b0;
        end else if (mismatch_set) begin
            mismatch_r <= 1'b1; // see [R02]
        end else if ((stat_wr && (reg_wdata_i[PTRCLR_BIT] || !reg_wdata_i[SELFTEST_BIT]))
                     || (test_acc && ptrclr_r)) begin
            mismatch_r <= 1'b0; // see [R15] [R16]
        end
    end

    // Queues
    logic [1:0][8:0] cnt_r;
    logic [1:0][8:0] wp_r;
    logic [1:0][8:0] rp_r;
    logic [1:0]      full;
    logic [1:0]      empty;
    logic [1:0]      host_hit;
    logic [1:0]      push;
    logic [1:0]      pop;
    logic            first_hit;

    assign host_hit[0] = reg_addr_i == ASYNC_FIRST_OFS || reg_addr_i == ASYNC_NEXT_OFS;
    assign host_hit[1] = reg_addr_i == ISO_FIRST_OFS || reg_addr_i == ISO_NEXT_OFS;
    assign first_hit   = reg_addr_i == ASYNC_FIRST_OFS || reg_addr_i == ISO_FIRST_OFS;

    for (genvar q = 0; q < 2; q++) begin : g_queue
        assign full[q]  = cnt_r[q] == depth_c[q];
        assign empty[q] = cnt_r[q] == 9'd0;
        // Writes into a full queue are dropped silently
        assign push[q]  = normal && reg_wr_i && host_hit[q] && !full[q]; // see [R10] [R18] [R03]

        always_ff @(posedge ref_clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                cnt_r[q] <= 9'd0;
            end else if (push[q] && !pop[q]) begin
                cnt_r[q] <= cnt_r[q] + 9'd1;
            end else if (pop[q] && !push[q]) begin
                cnt_r[q] <= cnt_r[q] - 9'd1;
            end
        end

        always_ff @(posedge ref_clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                wp_r[q] <= 9'd0;
            end else if (push[q]) begin
                wp_r[q] <= (wp_r[q] == depth_c[q] - 9'd1) ? 9'd0 : wp_r[q] + 9'd1;
            end
        end

        always_ff @(posedge ref_clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                rp_r[q] <= 9'd0;
            end else if (pop[q]) begin
                rp_r[q] <= (rp_r[q] == depth_c[q] - 9'd1) ? 9'd0 : rp_r[q] + 9'd1;
            end
        end
    end

    // Storage write port: self-test or queue load
    always_comb begin
        mem_wr.wr   = test_wr || push[0] || push[1];
        mem_wr.word = {first_hit, reg_wdata_i};
        mem_wr.addr = push[1] ? base_c[1] + wp_r[1] : base_c[0] + wp_r[0];
        if (test_wr) begin
            mem_wr.word = {marker_r, reg_wdata_i}; // see [R01] [R17]
            mem_wr.addr = test_addr;
        end
    end

    // Drain side; async queue goes first
    logic       land_r;
    logic       land_iso_r;
    logic [1:0] buf_cnt_r;
    logic       room;
    logic       issue;
    logic       sel_iso;

    // Words still in flight count against the two slots, so nothing is dropped
    assign room    = (buf_cnt_r + {1'b0, land_r}) < 2'd2;
    assign issue   = normal && !(empty[0] && empty[1]) && room; // see [R03]
    assign sel_iso = empty[0];
    assign pop[0]  = issue && !sel_iso;
    assign pop[1]  = issue && sel_iso;

    assign mem_rd_en   = issue || test_rd;
    assign mem_rd_addr = test_rd ? test_addr : base_c[sel_iso] + rp_r[sel_iso];

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            land_r     <= 1'b0;
            land_iso_r <= 1'b0;
        end else begin
            land_r     <= issue;
            land_iso_r <= sel_iso;
        end
    end

    tfs_store #(
        .WORDS (MEM_WORDS),
        .AW    (MEM_AW)
    ) u_store (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .wr_i      (mem_wr),
        .rd_en_i   (mem_rd_en),
        .rd_addr_i (mem_rd_addr),
        .rd_word_o (mem_rd_word)
    );

    // Two-entry output buffer
    tfs_tx_s buf_r [2];
    logic    buf_wi_r;
    logic    buf_ri_r;
    logic    buf_pop;

    assign tx_valid_o = buf_cnt_r != 2'd0;
    assign tx_word_o  = buf_r[buf_ri_r];
    assign buf_pop    = tx_valid_o && tx_ready_i;

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            buf_r[0] <= '0;
            buf_r[1] <= '0;
            buf_wi_r <= 1'b0;
        end else if (land_r) begin
            buf_r[buf_wi_r] <= {land_iso_r, mem_rd_word};
            buf_wi_r        <= !buf_wi_r;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            buf_ri_r <= 1'b0;
        end else if (buf_pop) begin
            buf_ri_r <= !buf_ri_r;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            buf_cnt_r <= 2'd0;
        end else if (land_r && !buf_pop) begin
            buf_cnt_r <= buf_cnt_r + 2'd1;
        end else if (buf_pop && !land_r) begin
            buf_cnt_r <= buf_cnt_r - 2'd1;
        end
    end

    // Flag snapshots, zero during reset and refreshed every cycle after it
    logic [31:0] async_flags_r;
    logic [31:0] iso_stat_r;
    logic [31:0] async_stat;

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            async_flags_r <= STATUS_RESET;
            iso_stat_r    <= STATUS_RESET; // see [R14]
        end else begin
            async_flags_r                    <= '0;
            async_flags_r[FULL_BIT]          <= full[0]; // see [R18]
            async_flags_r[EMPTY_BIT]         <= empty[0];
            async_flags_r[FREE_MSB:FREE_LSB] <= depth_c[0] - cnt_r[0]; // see [R08]
            iso_stat_r                       <= '0;
            iso_stat_r[FULL_BIT]             <= full[1]; // see [R10]
            iso_stat_r[EMPTY_BIT]            <= empty[1]; // see [R11]
            iso_stat_r[FREE_MSB:FREE_LSB]    <= depth_c[1] - cnt_r[1]; // see [R12]
        end
    end

    always_comb begin
        async_stat               = async_flags_r;
        async_stat[MISMATCH_BIT] = mismatch_r;
        async_stat[PTRCLR_BIT]   = ptrclr_r;
        async_stat[MARKER_BIT]   = marker_r;
        async_stat[SELFTEST_BIT] = selftest_r;
        async_stat[PTR_MSB:PTR_LSB] = ptr_r; // see [R06]
    end

    logic [31:0] rdata_r;

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_r <= 32'h0000_0000;
        end else if (reg_rd_i && reg_addr_i == ASYNC_STATUS_OFS) begin
            rdata_r <= async_stat; // see [R13]
        end else if (reg_rd_i && reg_addr_i == ISO_STATUS_OFS) begin
            rdata_r <= iso_stat_r;
        end else begin
            rdata_r <= 32'h0000_0000;
        end
    end

    assign reg_rdata_o = test_rd_q_r ? mem_rd_word.data : rdata_r; // see [R04]

    // Checks
    ptr_step_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see [R05]
        test_acc && !ptrclr_r |=> ptr_r == $past(ptr_r) + 9'd1)
        else $error("pointer did not advance by one");

    ptr_clear_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see [R16]
        test_acc && ptrclr_r && !stat_wr |=> ptr_r == 9'd1 && !ptrclr_r)
        else $error("clear request did not restart pointer");

    mismatch_set_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see [R02]
        test_rd ##1 mem_rd_word.first_quadlet_marker != marker_r |=> mismatch_r)
        else $error("marker mismatch not flagged");

    mismatch_clr_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see [R15]
        stat_wr && !reg_wdata_i[SELFTEST_BIT] && !mismatch_set |=> !mismatch_r)
        else $error("mismatch flag not cleared");

    test_write_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see [R01]
        test_wr |-> mem_wr.wr && mem_wr.addr == test_addr
                    && mem_wr.word == {marker_r, reg_wdata_i})
        else $error("self-test write went astray");

    selftest_quiet_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see [R03]
        selftest_r |=> $stable(cnt_r) && $stable(rp_r))
        else $error("queue moved in self-test mode");

    async_full_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see [R18]
        full[0] && reg_wr_i && host_hit[0] && !pop[0] |=> cnt_r[0] == $past(cnt_r[0]))
        else $error("async queue took a write while full");

    iso_full_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see [R10]
        full[1] && reg_wr_i && host_hit[1] && !pop[1] |=> cnt_r[1] == $past(cnt_r[1]))
        else $error("iso queue took a write while full");

    iso_free_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see [R11] [R12]
        ##1 1'b1 |=> iso_stat_r[EMPTY_BIT] == $past(empty[1])
                    && iso_stat_r[FREE_MSB:FREE_LSB] == depth_c[1] - $past(cnt_r[1]))
        else $error("iso status wrong");

endmodule : tfs_tx_status

// ### tfs_rx_sink.sv
`timescale 1ns/10ps
module tfs_rx_sink
    import tfs_pkg::*;
(
    input  wire logic ref_clk_i,
    input  wire logic resetn_i,
    input  wire logic stall_i,
    input  wire logic tx_valid_i,
    input  tfs_tx_s   tx_word_i,
    output logic      tx_ready_o
);
    tfs_tx_s got[$];

    // Stall is steered by the bench so back-pressure lands where a scenario wants it
    assign tx_ready_o = !stall_i;

    always @(posedge ref_clk_i) begin
        if (resetn_i && tx_valid_i && tx_ready_o) begin
            got.push_back(tx_word_i);
        end
    end
endmodule : tfs_rx_sink

// ### transmit_fifo_status_memory_selftest_mode_tb_top.sv
`timescale 1ns/10ps
module transmit_fifo_status_memory_selftest_mode_tb_top
    import tfs_pkg::*;
;
    // Small queues so a full queue is reached in a few writes
    localparam int          DEPTH   = 4;
    localparam logic [31:0] IDLE_ST = 32'h0200_0002;
    localparam logic [31:0] CTL_M   = 32'h0000_7ffc;

    logic        ref_clk_i   = 1'b0;
    logic        resetn_i    = 1'b0;
    logic [7:0]  reg_addr_i  = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0000_0000;
    logic        reg_wr_i    = 1'b0;
    logic        reg_rd_i    = 1'b0;
    logic        stall       = 1'b0;
    logic [31:0] reg_rdata_o;
    logic        tx_valid_o;
    logic        tx_ready_i;
    tfs_tx_s     tx_word_o;
    logic [31:0] rv;
    int          n_errors    = 0;
    int          num_checks  = 0;

    initial begin
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end

    tfs_tx_status #(.ASYNC_DEPTH(DEPTH), .ISO_DEPTH(DEPTH)) u_dut (
        .ref_clk_i  (ref_clk_i),
        .resetn_i   (resetn_i),
        .reg_addr_i (reg_addr_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_wr_i   (reg_wr_i),
        .reg_rd_i   (reg_rd_i),
        .reg_rdata_o(reg_rdata_o),
        .tx_valid_o (tx_valid_o),
        .tx_ready_i (tx_ready_i),
        .tx_word_o  (tx_word_o)
    );

    tfs_rx_sink u_sink (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .stall_i   (stall),
        .tx_valid_i(tx_valid_o),
        .tx_word_i (tx_word_o),
        .tx_ready_o(tx_ready_i)
    );

    task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        reg_wr_i    <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge ref_clk_i);
        reg_wr_i    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk_i);
        reg_rd_i   <= 1'b1;
        reg_addr_i <= a;
        @(posedge ref_clk_i);
        reg_rd_i   <= 1'b0;
        #1;
        d = reg_rdata_o;
    endtask : rd

    task automatic wait_words(input int n);
        for (int i = 0; i < 200 && u_sink.got.size() < n; i++) begin
            @(posedge ref_clk_i);
        end
        repeat (8) @(posedge ref_clk_i);
        check("word count", 34'(u_sink.got.size()), 34'(n));
    endtask : wait_words

    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic t_reset();
        repeat (4) @(posedge ref_clk_i);
        rd(ISO_STATUS_OFS, rv);
        check("iso status idle", 34'(rv), 34'(IDLE_ST));
        // Read data stand one cycle only, then fall back to zero
        @(posedge ref_clk_i);
        #1;
        check("read data drops", 34'(reg_rdata_o), 34'd0);
        rd(ASYNC_STATUS_OFS, rv);
        check("async status idle", 34'(rv), 34'(IDLE_ST));
        wr(ISO_STATUS_OFS, 32'hffff_ffff);
        rd(ISO_STATUS_OFS, rv);
        check("iso flags read only", 34'(rv), 34'(IDLE_ST));
        wr(ASYNC_STATUS_OFS, 32'hff80_0003);
        rd(ASYNC_STATUS_OFS, rv);
        check("async flags read only", 34'(rv), 34'(IDLE_ST));
        rd(8'h3c, rv);
        check("unmapped read", 34'(rv), 34'd0);
    endtask : t_reset

    task automatic t_selftest();
        wr(ASYNC_STATUS_OFS, 32'h0000_0030);
        wr(ASYNC_STATUS_OFS, 32'h0000_0038);
        rd(ASYNC_STATUS_OFS, rv);
        check("clear pending", 34'(rv & CTL_M), 34'h0000_0038);
        wr(TEST_DATA_OFS, 32'h1234_5678);
        wr(TEST_DATA_OFS, 32'h9abc_def0);
        wr(ASYNC_FIRST_OFS, 32'hdead_0001);
        rd(ASYNC_STATUS_OFS, rv);
        check("pointer after two", 34'(rv & CTL_M), 34'h0000_00b0);
        wr(ASYNC_STATUS_OFS, 32'h0000_0028);
        rd(TEST_DATA_OFS, rv);
        check("test word 0", 34'(rv), 34'h1234_5678);
        rd(TEST_DATA_OFS, rv);
        check("test word 1", 34'(rv), 34'h9abc_def0);
        rd(ASYNC_STATUS_OFS, rv);
        check("mismatch set", 34'(rv & CTL_M), 34'h0000_00a4);
        wr(ASYNC_STATUS_OFS, 32'h0000_0000);
        rd(ASYNC_STATUS_OFS, rv);
        check("mode off clears", 34'(rv & 32'h0000_003c), 34'd0);
        rd(TEST_DATA_OFS, rv);
        check("test port idle", 34'(rv), 34'd0);
        wait_words(0);
    endtask : t_selftest

    task automatic t_stream();
        stall <= 1'b1;
        wr(ASYNC_FIRST_OFS, 32'h0000_00a1);
        wr(ASYNC_NEXT_OFS, 32'h0000_00a2);
        wr(ISO_FIRST_OFS, 32'h0000_00b1);
        repeat (10) @(posedge ref_clk_i);
        check("nothing while stalled", 34'(u_sink.got.size()), 34'd0);
        stall <= 1'b0;
        wait_words(3);
        check("word a", u_sink.got[0], {2'b01, 32'h0000_00a1});
        check("word b", u_sink.got[1], {2'b00, 32'h0000_00a2});
        check("word c", u_sink.got[2], {2'b11, 32'h0000_00b1});
        u_sink.got.delete();
    endtask : t_stream

    task automatic t_full(input logic [7:0] base, input logic [7:0] st, input logic iso);
        rd(st, rv);
        check("free before burst", 34'(rv[31:23]), 34'(DEPTH));
        stall <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            wr((i == 0) ? base : base + 8'h04, 32'(i));
            if (i == 1) begin
                repeat (6) @(posedge ref_clk_i);
            end
        end
        rd(st, rv);
        check("full flag", 34'(rv & 32'hff80_0003), 34'h0000_0001);
        stall <= 1'b0;
        wait_words(6);
        for (int i = 0; i < 6 && i < u_sink.got.size(); i++) begin
            check("drained word", u_sink.got[i], {iso, (i == 0), 32'(i)});
        end
        u_sink.got.delete();
    endtask : t_full

    initial begin
        repeat (12) @(posedge ref_clk_i);
        check("read data in reset", 34'(reg_rdata_o), 34'd0);
        resetn_i <= 1'b1;
        t_reset();
        t_selftest();
        t_stream();
        t_full(ASYNC_FIRST_OFS, ASYNC_STATUS_OFS, 1'b0);
        t_full(ISO_FIRST_OFS, ISO_STATUS_OFS, 1'b1);
        wrap_up();
    end

    // About 180 cycles are needed; a hang is cut well after that
    initial begin
        repeat (5000) @(posedge ref_clk_i);
        n_errors++;
        wrap_up();
    end
endmodule : transmit_fifo_status_memory_selftest_mode_tb_top
